/* common/cat_pkg.sv */
// package: constants, types and bus carriers of the counter array time base
// assumes: one 100 MHz clock and AXI4-Lite register access with 32-bit data
`default_nettype none
package cat_pkg;
  localparam int unsigned NUM_MOD = 5;
  localparam int unsigned AW      = 12;
  localparam int unsigned CNT_W   = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CNT_LO  = 8'hc0;
  localparam logic [7:0] IDX_CNT_HI  = 8'hc1;
  localparam logic [7:0] IDX_MM0     = 8'hc2;
  localparam logic [7:0] IDX_CMP_LO0 = 8'hc8;
  localparam logic [7:0] IDX_CMP_HI0 = 8'hd0;
  localparam logic [7:0] IDX_CTRL    = 8'hd8;
  localparam logic [7:0] IDX_MODE    = 8'hd9;
  localparam logic [7:0] IDX_IRQ_ST  = 8'hdc;
  localparam logic [7:0] IDX_IRQ_MSK = 8'hdd;
  // counter mode register
  localparam int unsigned MODE_IDLE_GATE = 7;
  localparam int unsigned MODE_WDOG_EN   = 6;
  localparam int unsigned MODE_SRC_LSB   = 1;
  localparam int unsigned MODE_OVF_IRQ   = 0;
  localparam logic [7:0]  MODE_WMASK     = 8'hc7;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  // counter control register
  localparam int unsigned CTRL_OVF = 7;
  localparam int unsigned CTRL_RUN = 6;
  // per-module mode register
  localparam int unsigned MM_IRQ_EN  = 0;
  localparam int unsigned MM_PWM     = 1;
  localparam int unsigned MM_TOGGLE  = 2;
  localparam int unsigned MM_MATCH   = 3;
  localparam int unsigned MM_CAP_NEG = 4;
  localparam int unsigned MM_CAP_POS = 5;
  localparam int unsigned MM_CMP_EN  = 6;
  localparam int unsigned MM_W       = 7;
  localparam logic [6:0]  MM_RST     = 7'h00;
  // flag, status and mask layout: modules in 4..0, overflow in 5
  localparam int unsigned IRQ_OVF = 5;
  localparam int unsigned IRQ_W   = 6;
  localparam logic [5:0]  IRQ_RST = 6'h00;
  // prescaler for the divided clock sources
  localparam int unsigned DIV_SLOW   = 6;
  localparam logic [2:0]  PRESC_LAST = 3'(DIV_SLOW - 1);
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_DIV6  = 2'b00,
    SRC_DIV2  = 2'b01,
    SRC_T0OVF = 2'b10,
    SRC_EXT   = 2'b11
  } cat_src_e;

  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic          awvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          bready;
    logic [AW-1:0] araddr;
    logic          arvalid;
    logic          rready;
  } cat_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } cat_axi_rsp_s;
endpackage
`default_nettype wire

/* hw/cat_ccmod.sv */
// one compare/capture module running off the shared time base
// assumes: pin_in already synchronised, cnt_upd marks a freshly advanced count
`default_nettype none
module cat_ccmod #(
  parameter bit WDOG_CAPABLE = 1'b0 // module may act as watchdog
) (
  input  wire logic                      clk,      // clock
  input  wire logic                      rst,      // synchronous reset, high
  input  wire logic [cat_pkg::CNT_W-1:0] cnt,      // shared time base
  input  wire logic                      cnt_upd,  // cnt just advanced
  input  wire logic [cat_pkg::MM_W-1:0]  mode,     // module mode bits
  input  wire logic [cat_pkg::CNT_W-1:0] cmp,      // compare/capture value
  input  wire logic                      pin_in,   // synchronised pin level
  input  wire logic                      wdog_en,  // watchdog option
  output logic                           flag_set, // event pulse
  output logic                           cap_we,   // load cnt into cmp
  output logic                           pin_out,  // pin drive level
  output logic                           pin_own,  // module owns the pin
  output logic                           wdog_hit  // watchdog expiry pulse
);
  logic       prev_q, prev_d, out_q, out_d;
  logic [7:0] duty_q, duty_d;
  logic       rise, fall, match, is_wd, pwm_on;

  always_comb begin
    rise     = pin_in & ~prev_q;
    fall     = ~pin_in & prev_q;
    is_wd    = WDOG_CAPABLE & wdog_en;
    pwm_on   = mode[cat_pkg::MM_CMP_EN] & mode[cat_pkg::MM_PWM];
    match    = mode[cat_pkg::MM_CMP_EN] & ~mode[cat_pkg::MM_PWM] & cnt_upd & (cnt == cmp);
    cap_we   = (mode[cat_pkg::MM_CAP_POS] & rise) | (mode[cat_pkg::MM_CAP_NEG] & fall);
    wdog_hit = is_wd & match & mode[cat_pkg::MM_MATCH];
    flag_set = cap_we | (match & mode[cat_pkg::MM_MATCH] & ~is_wd);
    pin_own  = mode[cat_pkg::MM_CMP_EN] & (mode[cat_pkg::MM_TOGGLE] | mode[cat_pkg::MM_PWM]);
    prev_d   = pin_in;
    // duty reloads at the low-byte wrap so a period never sees a torn value
    duty_d   = (cnt_upd && cnt[7:0] == 8'h00) ? cmp[15:8] : duty_q;
    if (pwm_on) begin
      out_d = cnt[7:0] >= duty_q;
    end else if (match && mode[cat_pkg::MM_TOGGLE]) begin
      out_d = ~out_q;
    end else begin
      out_d = out_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      out_q  <= 1'b0;
      duty_q <= 8'h00;
    end else begin
      prev_q <= prev_d;
      out_q  <= out_d;
      duty_q <= duty_d;
    end
  end

  assign pin_out = out_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_CAP_EDGE: assert property (
    (mode[cat_pkg::MM_CAP_POS] && pin_in && !prev_q) ||
    (mode[cat_pkg::MM_CAP_NEG] && !pin_in && prev_q) |-> cap_we && flag_set)
    else $error("capture edge not taken");
  AST_TOGGLE: assert property (
    match && mode[cat_pkg::MM_TOGGLE] |=> out_q != $past(out_q))
    else $error("fast output did not toggle on match");
  AST_MATCH_FLAG: assert property (
    mode[cat_pkg::MM_CMP_EN] && mode[cat_pkg::MM_MATCH] && !mode[cat_pkg::MM_PWM] &&
    cnt_upd && cnt == cmp && !is_wd |-> flag_set)
    else $error("match did not raise flag");
  AST_WD_ONLY4: assert property (
    !WDOG_CAPABLE || !wdog_en |-> !wdog_hit)
    else $error("watchdog fired on a plain module");
  AST_WD_NOFLAG: assert property (
    wdog_hit |-> !flag_set || cap_we)
    else $error("watchdog match raised a module flag");
endmodule
`default_nettype wire

/* hw/cat_timebase.sv */
// counter array time base: mode/control registers, shared counter, five modules
// assumes: AXI4-Lite master on clk; port logic supplies gpio_out/gpio_oe
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module cat_timebase (
  input  wire logic                  clk,           // 100 MHz clock
  input  wire logic                  rst,           // synchronous reset, high
  input  wire cat_pkg::cat_axi_req_s axi_req,       // axi4-lite requests
  output var  cat_pkg::cat_axi_rsp_s axi_rsp,       // axi4-lite answers
  input  wire logic                  t0_ovf,        // timer 0 overflow pulse
  input  wire logic                  cpu_idle,      // cpu in idle mode
  input  wire logic                  ext_count_in,  // external count pin
  input  wire logic [4:0]            module_io_in,  // module pin levels
  input  wire logic [4:0]            gpio_out,      // port latch value
  input  wire logic [4:0]            gpio_oe,       // port drive enable
  output logic      [4:0]            module_io_out, // module pin level out
  output logic      [4:0]            module_io_oe,  // module pin drive enable
  output logic                       irq,           // merged interrupt
  output logic                       wdog_rst       // watchdog reset pulse
);
  localparam int unsigned NM = cat_pkg::NUM_MOD;
  localparam int unsigned IW = cat_pkg::IRQ_W;
  typedef logic [cat_pkg::CNT_W-1:0] cat_cnt_t;

  function automatic logic [8:0] reg_idx(input logic [cat_pkg::AW-1:0] addr);
    reg_idx = {addr[cat_pkg::AW-1:10] == 2'h0, addr[9:2]};
  endfunction

  function automatic logic reg_known(input logic [8:0] ix);
    logic [7:0] i;
    i = ix[7:0];
    reg_known = ix[8] && (i == cat_pkg::IDX_MODE || i == cat_pkg::IDX_CTRL ||
      i == cat_pkg::IDX_CNT_LO || i == cat_pkg::IDX_CNT_HI ||
      i == cat_pkg::IDX_IRQ_ST || i == cat_pkg::IDX_IRQ_MSK ||
      (i >= cat_pkg::IDX_MM0 && i < cat_pkg::IDX_MM0 + 8'(NM)) ||
      (i >= cat_pkg::IDX_CMP_LO0 && i < cat_pkg::IDX_CMP_LO0 + 8'(NM)) ||
      (i >= cat_pkg::IDX_CMP_HI0 && i < cat_pkg::IDX_CMP_HI0 + 8'(NM)));
  endfunction

  // bus state
  logic                  awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
  logic [cat_pkg::AW-1:0] awa_q, awa_d;
  logic [31:0]           wd_q, wd_d, rd_q, rd_d, rd_word;
  logic [3:0]            ws_q, ws_d;
  logic [1:0]            br_q, br_d, rr_q, rr_d;
  logic                  aw_fire, w_fire, ar_fire, wr_go;
  logic [8:0]            wr_ix, ar_ix;
  // core state
  logic [7:0]            mode_q, mode_d;
  logic                  run_q, run_d, irq_q, irq_d, wdog_q, wdog_d, cnt_upd_q;
  logic [IW-1:0]         flag_q, flag_d, mask_q, mask_d, flag_clr, flag_sw, irq_en;
  logic [cat_pkg::MM_W-1:0] mm_q [NM];
  logic [cat_pkg::MM_W-1:0] mm_d [NM];
  cat_cnt_t              cmp_q [NM];
  cat_cnt_t              cmp_d [NM];
  cat_cnt_t              cnt_q, cnt_d;
  logic [2:0]            presc_q, presc_d;
  logic                  evt, cnt_en, tick, ovf;
  cat_pkg::cat_src_e     src;
  // pin synchronisers and module outputs
  logic                  ext_s1_q, ext_s2_q, ext_prev_q;
  logic [NM-1:0]         pin_s1_q, pin_s2_q;
  logic [NM-1:0]         mod_set, cap_we, pin_out, pin_own, wdog_hit;

  // axi4-lite slave
  assign aw_fire = axi_req.awvalid & ~awh_q & ~bv_q;
  assign w_fire  = axi_req.wvalid & ~wh_q & ~bv_q;
  assign ar_fire = axi_req.arvalid & ~rv_q;
  assign wr_go   = awh_q & wh_q & ~bv_q;
  assign wr_ix   = reg_idx(awa_q);
  assign ar_ix   = reg_idx(axi_req.araddr);

  always_comb begin
    awh_d = awh_q;
    awa_d = awa_q;
    wh_d  = wh_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (aw_fire) begin
      awh_d = 1'b1;
      awa_d = axi_req.awaddr;
    end
    if (w_fire) begin
      wh_d = 1'b1;
      wd_d = axi_req.wdata;
      ws_d = axi_req.wstrb;
    end
    if (wr_go) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = reg_known(wr_ix) ? cat_pkg::RESP_OKAY : cat_pkg::RESP_SLVERR;
    end else if (bv_q && axi_req.bready) begin
      bv_d = 1'b0;
    end
    if (ar_fire) begin
      rv_d = 1'b1;
      rd_d = rd_word;
      rr_d = reg_known(ar_ix) ? cat_pkg::RESP_OKAY : cat_pkg::RESP_SLVERR;
    end else if (rv_q && axi_req.rready) begin
      rv_d = 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (reg_known(ar_ix)) begin
      case (ar_ix[7:0])
        cat_pkg::IDX_MODE:    rd_word[7:0] = mode_q;
        cat_pkg::IDX_CTRL:    rd_word[7:0] = {flag_q[cat_pkg::IRQ_OVF], run_q, 1'b0, flag_q[4:0]};
        cat_pkg::IDX_CNT_LO:  rd_word[7:0] = cnt_q[7:0];
        cat_pkg::IDX_CNT_HI:  rd_word[7:0] = cnt_q[15:8];
        cat_pkg::IDX_IRQ_ST:  rd_word[IW-1:0] = flag_q;
        cat_pkg::IDX_IRQ_MSK: rd_word[IW-1:0] = mask_q;
        default: begin
          for (int i = 0; i < NM; i++) begin
            if (ar_ix[7:0] == cat_pkg::IDX_MM0 + 8'(i)) rd_word[6:0] = mm_q[i];
            if (ar_ix[7:0] == cat_pkg::IDX_CMP_LO0 + 8'(i)) rd_word[7:0] = cmp_q[i][7:0];
            if (ar_ix[7:0] == cat_pkg::IDX_CMP_HI0 + 8'(i)) rd_word[7:0] = cmp_q[i][15:8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awh_q <= 1'b0;
      awa_q <= '0;
      wh_q  <= 1'b0;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
      bv_q  <= 1'b0;
      br_q  <= cat_pkg::RESP_OKAY;
      rv_q  <= 1'b0;
      rd_q  <= 32'h0000_0000;
      rr_q  <= cat_pkg::RESP_OKAY;
    end else begin
      awh_q <= awh_d;
      awa_q <= awa_d;
      wh_q  <= wh_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      rr_q  <= rr_d;
    end
  end

  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = ~awh_q & ~bv_q;
    axi_rsp.wready  = ~wh_q & ~bv_q;
    axi_rsp.bvalid  = bv_q;
    axi_rsp.bresp   = br_q;
    axi_rsp.arready = ~rv_q;
    axi_rsp.rvalid  = rv_q;
    axi_rsp.rdata   = rd_q;
    axi_rsp.rresp   = rr_q;
  end

  // pin synchronisers; first stages feed only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
    end else begin
      ext_s1_q   <= ext_count_in;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      pin_s1_q   <= module_io_in;
      pin_s2_q   <= pin_s1_q;
    end
  end

  // count source and gating
  assign src = cat_pkg::cat_src_e'(mode_q[cat_pkg::MODE_SRC_LSB +: 2]);

  always_comb begin
    case (src)
      cat_pkg::SRC_DIV6:  evt = presc_q == cat_pkg::PRESC_LAST;
      cat_pkg::SRC_DIV2:  evt = presc_q[0];
      cat_pkg::SRC_T0OVF: evt = t0_ovf;
      cat_pkg::SRC_EXT:   evt = ext_s2_q & ~ext_prev_q;
      default:            evt = 1'b0;
    endcase
  end

  assign cnt_en = run_q & ~(mode_q[cat_pkg::MODE_IDLE_GATE] & cpu_idle);
  assign tick   = evt & cnt_en;
  assign ovf    = tick & (cnt_q == 16'hffff);

  always_comb begin
    for (int i = 0; i < NM; i++) irq_en[i] = mm_q[i][cat_pkg::MM_IRQ_EN];
    irq_en[cat_pkg::IRQ_OVF] = mode_q[cat_pkg::MODE_OVF_IRQ];
  end

  always_comb begin
    mode_d   = mode_q;
    run_d    = run_q;
    mask_d   = mask_q;
    mm_d     = mm_q;
    cmp_d    = cmp_q;
    flag_clr = '0;
    flag_sw  = '0;
    presc_d  = (presc_q == cat_pkg::PRESC_LAST) ? 3'h0 : presc_q + 3'h1;
    cnt_d    = tick ? cnt_q + 16'h0001 : cnt_q;
    if (wr_go && reg_known(wr_ix) && ws_q[0]) begin
      case (wr_ix[7:0])
        cat_pkg::IDX_MODE:    mode_d = wd_q[7:0] & cat_pkg::MODE_WMASK;
        cat_pkg::IDX_CTRL: begin
          run_d    = wd_q[cat_pkg::CTRL_RUN];
          flag_clr = ~{wd_q[cat_pkg::CTRL_OVF], wd_q[4:0]};
          flag_sw  = {wd_q[cat_pkg::CTRL_OVF], 5'h00};
        end
        cat_pkg::IDX_CNT_LO:  cnt_d[7:0] = wd_q[7:0];
        cat_pkg::IDX_CNT_HI:  cnt_d[15:8] = wd_q[7:0];
        cat_pkg::IDX_IRQ_ST:  flag_clr = wd_q[IW-1:0];
        cat_pkg::IDX_IRQ_MSK: mask_d = wd_q[IW-1:0];
        default: begin
          for (int i = 0; i < NM; i++) begin
            if (wr_ix[7:0] == cat_pkg::IDX_MM0 + 8'(i)) mm_d[i] = wd_q[6:0];
            if (wr_ix[7:0] == cat_pkg::IDX_CMP_LO0 + 8'(i)) cmp_d[i][7:0] = wd_q[7:0];
            if (wr_ix[7:0] == cat_pkg::IDX_CMP_HI0 + 8'(i)) cmp_d[i][15:8] = wd_q[7:0];
          end
        end
      endcase
    end
    for (int i = 0; i < NM; i++) begin
      if (cap_we[i]) cmp_d[i] = cnt_q;
    end
    // hardware sets win over a clear in the same cycle
    flag_d = (flag_q & ~flag_clr) | flag_sw | {ovf, mod_set};
    irq_d  = |(flag_q & irq_en & mask_q);
    wdog_d = |wdog_hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q    <= cat_pkg::MODE_RST;
      run_q     <= 1'b0;
      flag_q    <= cat_pkg::IRQ_RST;
      mask_q    <= cat_pkg::IRQ_RST;
      cnt_q     <= cat_pkg::CNT_RST;
      presc_q   <= 3'h0;
      cnt_upd_q <= 1'b0;
      irq_q     <= 1'b0;
      wdog_q    <= 1'b0;
      for (int i = 0; i < NM; i++) begin
        mm_q[i]  <= cat_pkg::MM_RST;
        cmp_q[i] <= cat_pkg::CNT_RST;
      end
    end else begin
      mode_q    <= mode_d;
      run_q     <= run_d;
      flag_q    <= flag_d;
      mask_q    <= mask_d;
      cnt_q     <= cnt_d;
      presc_q   <= presc_d;
      cnt_upd_q <= tick;
      irq_q     <= irq_d;
      wdog_q    <= wdog_d;
      mm_q      <= mm_d;
      cmp_q     <= cmp_d;
    end
  end

  for (genvar g = 0; g < NM; g++) begin : g_mod
    cat_ccmod #(
      .WDOG_CAPABLE(g == NM - 1)
    ) u_mod (
      .clk      (clk),
      .rst      (rst),
      .cnt      (cnt_q),
      .cnt_upd  (cnt_upd_q),
      .mode     (mm_q[g]),
      .cmp      (cmp_q[g]),
      .pin_in   (pin_s2_q[g]),
      .wdog_en  (mode_q[cat_pkg::MODE_WDOG_EN]),
      .flag_set (mod_set[g]),
      .cap_we   (cap_we[g]),
      .pin_out  (pin_out[g]),
      .pin_own  (pin_own[g]),
      .wdog_hit (wdog_hit[g])
    );
  end

  // pins not claimed by a module stay with the port logic
  assign module_io_out = (pin_own & pin_out) | (~pin_own & gpio_out);
  assign module_io_oe  = pin_own | gpio_oe;
  assign irq           = irq_q;
  assign wdog_rst      = wdog_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_DIV6: assert property (
    cnt_en && src == cat_pkg::SRC_DIV6 && !wr_go |=>
    (cnt_q != $past(cnt_q)) == ($past(presc_q) == cat_pkg::PRESC_LAST))
    else $error("divide by six source miscounted");
  AST_T0: assert property (
    cnt_en && src == cat_pkg::SRC_T0OVF && t0_ovf && !wr_go |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("timer 0 overflow not counted");
  AST_IDLE_STOP: assert property (
    mode_q[cat_pkg::MODE_IDLE_GATE] && cpu_idle && !wr_go |=> $stable(cnt_q))
    else $error("counter ran in gated idle");
  AST_IDLE_RUN: assert property (
    run_q && !mode_q[cat_pkg::MODE_IDLE_GATE] && cpu_idle && src == cat_pkg::SRC_DIV2 &&
    presc_q[0] && !wr_go |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("counter stopped in ungated idle");
  AST_WDOG_OUT: assert property (
    wdog_hit != '0 |=> wdog_rst)
    else $error("watchdog hit without reset pulse");
  AST_SHARED_BASE: assert property (
    cnt_upd_q && mm_q[0][cat_pkg::MM_CMP_EN] && mm_q[0][cat_pkg::MM_MATCH] &&
    !mm_q[0][cat_pkg::MM_PWM] && cnt_q == cmp_q[0] |=> flag_q[0])
    else $error("module 0 missed a match on the shared count");
  AST_IRQ: assert property (
    (flag_q & irq_en & mask_q) != '0 |=> irq)
    else $error("pending request not on interrupt line");
  AST_IRQ_LOW: assert property (
    (flag_q & irq_en & mask_q) == '0 |=> !irq)
    else $error("interrupt without enabled flag");
  AST_PIN_FREE: assert property (
    pin_own == '0 |-> module_io_oe == gpio_oe && module_io_out == gpio_out)
    else $error("free pin not left to port logic");
  AST_OVF_SET: assert property (
    ovf |=> flag_q[cat_pkg::IRQ_OVF])
    else $error("overflow flag not set");
  AST_OVF_HOLD: assert property (
    flag_q[cat_pkg::IRQ_OVF] && !wr_go |=> flag_q[cat_pkg::IRQ_OVF])
    else $error("overflow flag cleared without a write");
  AST_RUN: assert property (
    !run_q && !wr_go |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  AST_WRAP: assert property (
    ovf && !wr_go |=> cnt_q == 16'h0000 && flag_q[cat_pkg::IRQ_OVF])
    else $error("counter did not wrap to zero");
endmodule
`default_nettype wire

/* tb/cat_pin_model.sv */
// pin model: count pin bursts and module pin levels
// assumes: block clock; undriven module pins pulled up
`default_nettype none
module cat_pin_model (
  input  wire logic       clk,          // clock
  input  wire logic       start,        // begin a burst
  input  wire logic [7:0] n_edges,      // rising edges in burst
  input  wire logic [4:0] pin_out,      // block drive level
  input  wire logic [4:0] pin_oe,       // block drive enable
  output logic            ext_count_in, // count pin
  output logic [4:0]      module_io_in  // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q = 8'h00;
  logic [1:0] ph_q = 2'h0;
  // two clocks low, two high per edge
  always @(posedge clk) begin
    if (start) begin
      left_q <= n_edges;
      ph_q <= 2'h0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3)
        left_q <= left_q - 8'h01;
    end
  end
  assign ext_count_in = (left_q != 8'h00) && ph_q[1];
  assign module_io_in = (pin_oe & pin_out) | ~pin_oe;
endmodule
`default_nettype wire

/* tb/tb.sv */
// testbench: registers, count sources, idle, overflow irq, watchdog
// assumes: cat_pkg, cat_timebase and cat_pin_model compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk, rst, t0_ovf, cpu_idle, start, ext, irq, wdog_rst;
  logic [7:0]            n_edges;
  logic [4:0]            pin_in, pin_out, pin_oe, gpio_out, gpio_oe;
  logic [31:0]           d;
  logic [1:0]            r;
  cat_pkg::cat_axi_req_s req;
  cat_pkg::cat_axi_rsp_s rsp;
  int                    n_errors = 0, n_compared = 0, cyc = 0, n_wdog = 0;
  cat_timebase dut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .t0_ovf(t0_ovf),
    .cpu_idle(cpu_idle), .ext_count_in(ext), .module_io_in(pin_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .module_io_out(pin_out), .module_io_oe(pin_oe), .irq(irq),
    .wdog_rst(wdog_rst));
  cat_pin_model pins (.clk(clk), .start(start), .n_edges(n_edges), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_count_in(ext), .module_io_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdog_rst === 1'b1)
      n_wdog <= n_wdog + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk);
    req.awaddr <= {2'b00, idx, 2'b00};
    req.wdata <= {24'h000000, v};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    req.araddr <= {2'b00, idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic cnt(output logic [15:0] c);
    rd(cat_pkg::IDX_CNT_LO, d, r);
    c[7:0] = d[7:0];
    rd(cat_pkg::IDX_CNT_HI, d, r);
    c[15:8] = d[7:0];
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) t0_ovf <= 1'b1;
      @(posedge clk) t0_ovf <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  // stop, clear flags and count, set mode, run
  task automatic setup(input logic [7:0] m);
    wr(cat_pkg::IDX_CTRL, 8'h00);
    wr(cat_pkg::IDX_CNT_LO, 8'h00);
    wr(cat_pkg::IDX_CNT_HI, 8'h00);
    wr(cat_pkg::IDX_MODE, m);
    wr(cat_pkg::IDX_CTRL, 8'h40);
  endtask
  task automatic t_reg();
    rd(cat_pkg::IDX_MODE, d, r);
    chk(d, 32'h00000000);
    wr(cat_pkg::IDX_MODE, 8'hff);
    rd(cat_pkg::IDX_MODE, d, r);
    chk(d, 32'h000000c7);
    rd(8'h00, d, r);
    chk({30'h0, r}, {30'h0, cat_pkg::RESP_SLVERR});
    chk({27'h0, pin_oe}, 32'h0000000a);
    chk({27'h0, pin_out}, 32'h00000015);
  endtask
  task automatic t_src();
    logic [15:0] c;
    int lo[4] = '{10, 30, 7, 5};
    int hi[4] = '{12, 34, 7, 5};
    for (int s = 0; s < 4; s++) begin
      setup(8'(s << 1));
      if (s < 2)
        repeat (60) @(posedge clk);
      else if (s == 2)
        pulse(7);
      else begin
        start <= 1'b1;
        n_edges <= 8'h05;
        @(posedge clk) start <= 1'b0;
        repeat (30) @(posedge clk);
      end
      wr(cat_pkg::IDX_CTRL, 8'h00);
      cnt(c);
      chk({31'h0, c >= lo[s] && c <= hi[s]}, 32'h1);
    end
  endtask
  task automatic t_idle();
    logic [15:0] c;
    cpu_idle <= 1'b1;
    setup(8'h84);
    pulse(3);
    cnt(c);
    chk(32'(c), 32'h0);
    wr(cat_pkg::IDX_MODE, 8'h04);
    pulse(3);
    wr(cat_pkg::IDX_CTRL, 8'h00);
    pulse(2);
    cnt(c);
    chk(32'(c), 32'h3);
    cpu_idle <= 1'b0;
  endtask
  task automatic t_ovf();
    logic [15:0] c;
    setup(8'h05);
    wr(cat_pkg::IDX_CTRL, 8'h00);
    wr(cat_pkg::IDX_CNT_LO, 8'hff);
    wr(cat_pkg::IDX_CNT_HI, 8'hff);
    wr(cat_pkg::IDX_IRQ_MSK, 8'h20);
    wr(cat_pkg::IDX_CTRL, 8'h40);
    pulse(1);
    cnt(c);
    chk(32'(c), 32'h0);
    rd(cat_pkg::IDX_CTRL, d, r);
    chk(d & 32'h80, 32'h80);
    chk(32'(irq), 32'h1);
    wr(cat_pkg::IDX_IRQ_MSK, 8'h00);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(cat_pkg::IDX_IRQ_MSK, 8'h20);
    wr(cat_pkg::IDX_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    rd(cat_pkg::IDX_CTRL, d, r);
    chk(d & 32'h80, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  // module 4 compare match at count 5, with and without the watchdog option
  task automatic t_wdog(input logic wd);
    int w0;
    w0 = n_wdog;
    wr(cat_pkg::IDX_MM0 + 8'h04, 8'h48);
    wr(cat_pkg::IDX_CMP_LO0 + 8'h04, 8'h05);
    wr(cat_pkg::IDX_CMP_HI0 + 8'h04, 8'h00);
    setup({1'b0, wd, 6'h04});
    pulse(5);
    rd(cat_pkg::IDX_CTRL, d, r);
    chk(32'(n_wdog - w0), {31'h0, wd});
    chk(d & 32'h10, wd ? 32'h0 : 32'h10);
  endtask
  // module 0 toggles on a match, module 1 captures a rising pin, module 2 runs pwm
  task automatic t_mod();
    wr(cat_pkg::IDX_MM0, 8'h4d);
    wr(cat_pkg::IDX_CMP_LO0, 8'h03);
    wr(cat_pkg::IDX_CMP_HI0, 8'h00);
    wr(cat_pkg::IDX_MM0 + 8'h01, 8'h21);
    wr(cat_pkg::IDX_MM0 + 8'h02, 8'h42);
    wr(cat_pkg::IDX_CMP_HI0 + 8'h02, 8'h80);
    wr(cat_pkg::IDX_IRQ_MSK, 8'h01);
    setup(8'h04);
    pulse(3);
    chk({31'h0, pin_out[0]}, 32'h1);
    chk({31'h0, pin_oe[0]}, 32'h1);
    chk(32'(irq), 32'h1);
    gpio_out <= 5'h17;
    repeat (5) @(posedge clk);
    rd(cat_pkg::IDX_CMP_LO0 + 8'h01, d, r);
    chk(d, 32'h00000003);
    rd(cat_pkg::IDX_CTRL, d, r);
    chk(d & 32'h1f, 32'h00000003);
    wr(cat_pkg::IDX_CNT_LO, 8'hff);
    pulse(1);
    chk({31'h0, pin_out[2]}, 32'h0);
    wr(cat_pkg::IDX_CNT_LO, 8'h90);
    repeat (2) @(posedge clk);
    chk({31'h0, pin_out[2]}, 32'h1);
  endtask
  initial begin
    rst = 1'b1;
    t0_ovf = 1'b0;
    cpu_idle = 1'b0;
    start = 1'b0;
    n_edges = 8'h00;
    gpio_out = 5'h15;
    gpio_oe = 5'h0a;
    req = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reg();
    t_src();
    t_idle();
    t_ovf();
    t_wdog(1'b1);
    t_wdog(1'b0);
    t_mod();
    summarize();
  end
endmodule
`default_nettype wire
